/* File: inc/lmscp_pkg.sv */
package lmscp_pkg;
	// Frame layout: read flag on top, seven address bits, one data byte.
	localparam int WORD_BITS = 16;
	localparam int RW_BIT = 15;
	localparam int DIGITS = 4;
	// Register addresses carried in bits 14 to 8 of a command word.
	localparam logic [6:0] ADDR_NOOP = 7'h00;
	localparam logic [6:0] ADDR_CONFIG = 7'h04;
	localparam logic [6:0] ADDR_PRIMARY = 7'h20;
	localparam logic [6:0] ADDR_ALTERNATE = 7'h40;
	localparam logic [6:0] ADDR_BOTH = 7'h60;
	// Configuration bit that lets the alternate plane take part.
	localparam int CFG_BLINK_EN_BIT = 3;
	// Values after reset, and what a read of an unreadable address returns.
	localparam logic [7:0] DIGIT_RESET = 8'h20;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// Font split: fixed characters first, user characters above them.
	localparam logic [6:0] FONT_FIXED = 7'h68;
	localparam int FONT_USER = 24;
	// Timing.
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_NS = 80;
	localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYCLES - 1);
	localparam int BLINK_HALF_US = 500;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_US * 1000 / CLK_PERIOD_NS;
	// Controller registers on APB.
	localparam logic [11:0] APB_CMD = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam logic [11:0] APB_RXDATA = 12'h008;
	localparam int CMD_HOLD_BIT = 16;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	localparam logic [3:0] BIT_LAST = 4'hF;
endpackage

/* File: inc/lmscp_if.sv */
`timescale 1ns/1ns
// Four-wire command link; the data output is push-pull and never floats.
interface lmscp_if;
	logic sclk; // Serial clock from the master.
	logic csB; // Active-low frame select.
	logic din; // Master to device data.
	logic dout; // Device to master data.
	modport dev (input sclk, input csB, input din, output dout);
	modport host (output sclk, output csB, output din, input dout);
endinterface

/* File: hw/lmscp_dev.sv */
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Summary of operation
// R1: Ignore clock and data while select high.
// R2: Sample data on each rising clock.
// R3: Data output always driven, never floating.
// R4: Word is flag, seven address, data byte.
// R5: Output follows input 15.5 clocks later.
// R6: Master gives sixteen clocks per chained device.
// R7: Master sends no-op to untouched chained devices.
// R8: Select rise latches word, then executes it.
// R9: Write: clock low, select low, sixteen bits.
// R10: Select rises while clock still high.
// R11: Odd frames keep the last sixteen bits.
// R12: Read sets top bit; data byte discarded.
// R13: Read loads register into low positions.
// R14: Master reads second byte of next frame.
// R15: Two planes of four digit bytes.
// R16: Blink off shows primary plane only.
// R17: Blink on alternates planes each phase.
// R18: Low seven bits index the font.
// R19: Top bit inverts the font pattern.
// R20: Font holds 104 fixed, 24 user characters.
// R21: Decode primary, alternate and both-plane addresses.
// R22: Configuration bit 3 enables blinking.
// R23: No-op changes no state.
// R24: Shift register never clears between frames.
module lmscp_dev #(
	parameter int BLINK_HALF = lmscp_pkg::BLINK_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	lmscp_if.dev link,
	output logic [lmscp_pkg::DIGITS-1:0][6:0] digitChar,
	output logic [lmscp_pkg::DIGITS-1:0] digitInvert,
	output logic [lmscp_pkg::DIGITS-1:0] digitUserFont,
	output logic blinkPhase,
	output logic blinkEnabled
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic [1:0] sclkSync_q; // Two stages; only stage 1 is read.
	logic [1:0] csSync_q;
	logic [1:0] dinSync_q;
	logic sclkPrev_q; // Stage 1 delayed, for edge finding.
	logic csPrev_q;

	// The first stage of each chain feeds only its second stage.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclkSync_q <= 2'h0;
			csSync_q <= 2'h3;
			dinSync_q <= 2'h0;
			sclkPrev_q <= 1'b0;
			csPrev_q <= 1'b1;
		end else begin
			sclkSync_q <= {sclkSync_q[0], link.sclk};
			csSync_q <= {csSync_q[0], link.csB};
			dinSync_q <= {dinSync_q[0], link.din};
			sclkPrev_q <= sclkSync_q[1];
			csPrev_q <= csSync_q[1];
		end
	end

	logic selected; // Frame open.
	logic sclkRise;
	logic sclkFall;
	logic csRise;

	// Clock edges count only inside a frame.
	assign selected = !csSync_q[1];
	assign sclkRise = selected && sclkSync_q[1] && !sclkPrev_q; // R1 R2
	assign sclkFall = selected && !sclkSync_q[1] && sclkPrev_q; // R1
	assign csRise = csSync_q[1] && !csPrev_q;

	////////////////////////////////////////////////////////////////////////////
	// Shift register, latch and command execution.

	logic [15:0] shift_q, shift_d; // Serial shift register.
	logic [15:0] latch_q, latch_d; // Word captured at frame end.
	logic exec_q, exec_d; // One-cycle pulse: execute the latched word.
	logic dout_q, dout_d; // Serial data output.
	logic [lmscp_pkg::DIGITS-1:0][7:0] primary_q, primary_d; // Primary plane.
	logic [lmscp_pkg::DIGITS-1:0][7:0] alternate_q, alternate_d; // Alternate plane.
	logic [7:0] config_q, config_d; // Configuration byte.
	logic [6:0] cmdAddr; // Address field of the latched word.
	logic [7:0] cmdData; // Data field of the latched word.
	logic cmdRead; // Read flag of the latched word.
	logic [1:0] digitIdx; // Digit selected by the address.
	logic [7:0] readValue; // Register contents for a read.

	assign cmdRead = latch_q[lmscp_pkg::RW_BIT]; // R4
	assign cmdAddr = latch_q[14:8]; // R4
	assign cmdData = latch_q[7:0]; // R4
	assign digitIdx = cmdAddr[1:0];

	// Read mux; the both-plane addresses read as zero and unknown ones too.
	always_comb begin
		readValue = lmscp_pkg::READ_ZERO;
		if (cmdAddr[6:2] == lmscp_pkg::ADDR_PRIMARY[6:2]) begin
			readValue = primary_q[digitIdx];
		end else if (cmdAddr[6:2] == lmscp_pkg::ADDR_ALTERNATE[6:2]) begin
			readValue = alternate_q[digitIdx];
		end else if (cmdAddr == lmscp_pkg::ADDR_CONFIG) begin
			readValue = config_q;
		end // R21
	end

	// Next state. The shift register is never cleared, so a short frame
	// latches stale bits from before it; this is intended behaviour.
	always_comb begin
		shift_d = shift_q;
		latch_d = latch_q;
		exec_d = 1'b0;
		dout_d = dout_q;
		primary_d = primary_q;
		alternate_d = alternate_q;
		config_d = config_q;
		// Shift on each rising clock, newest bit at the bottom.
		if (sclkRise) begin
			shift_d = {shift_q[14:0], dinSync_q[1]}; // R2 R11 R24
		end
		// Top bit goes out on falling clock; it entered 15.5 clocks ago.
		if (sclkFall) begin
			dout_d = shift_q[15]; // R5
		end
		// Frame end: copy the whole register, execute next cycle.
		if (csRise) begin
			latch_d = shift_q; // R8 R11
			exec_d = 1'b1; // R8
		end
		if (exec_q) begin
			// Present the word's top bit before the next frame's first rise.
			dout_d = shift_q[15]; // R5
			if (cmdRead) begin
				// Data byte of a read is dropped; register goes in its place.
				shift_d[7:0] = readValue; // R12 R13
			end else if (cmdAddr[6:2] == lmscp_pkg::ADDR_PRIMARY[6:2]) begin
				primary_d[digitIdx] = cmdData; // R15 R21
			end else if (cmdAddr[6:2] == lmscp_pkg::ADDR_ALTERNATE[6:2]) begin
				alternate_d[digitIdx] = cmdData; // R15 R21
			end else if (cmdAddr[6:2] == lmscp_pkg::ADDR_BOTH[6:2]) begin
				primary_d[digitIdx] = cmdData; // R15 R21
				alternate_d[digitIdx] = cmdData; // R15 R21
			end else if (cmdAddr == lmscp_pkg::ADDR_CONFIG) begin
				config_d = cmdData; // R22
			end
			// A no-op and unmapped addresses fall through untouched.
		end // R23
	end

	// Registers only.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_q <= 16'h0000;
			latch_q <= 16'h0000;
			exec_q <= 1'b0;
			dout_q <= 1'b0; // R3
			primary_q <= {lmscp_pkg::DIGITS{lmscp_pkg::DIGIT_RESET}};
			alternate_q <= {lmscp_pkg::DIGITS{lmscp_pkg::DIGIT_RESET}};
			config_q <= lmscp_pkg::CONFIG_RESET;
		end else begin
			shift_q <= shift_d;
			latch_q <= latch_d;
			exec_q <= exec_d;
			dout_q <= dout_d;
			primary_q <= primary_d;
			alternate_q <= alternate_d;
			config_q <= config_d;
		end
	end

	// The output is a plain flip-flop, so it is driven even between frames.
	assign link.dout = dout_q; // R3

	////////////////////////////////////////////////////////////////////////////
	// Blink timebase.

	logic [31:0] blinkCnt_q, blinkCnt_d; // Cycles in the current phase.
	logic phase_q, phase_d; // Low shows primary, high alternate.
	logic blinkOn; // Blinking enabled by software.

	assign blinkOn = config_q[lmscp_pkg::CFG_BLINK_EN_BIT]; // R22

	// The timebase rests in phase low while blinking is off, so enabling
	// always starts on the primary plane.
	always_comb begin
		blinkCnt_d = 32'h00000000;
		phase_d = 1'b0;
		if (blinkOn) begin
			blinkCnt_d = blinkCnt_q + 32'h00000001;
			phase_d = phase_q;
			if (blinkCnt_q == 32'(BLINK_HALF - 1)) begin
				blinkCnt_d = 32'h00000000;
				phase_d = !phase_q; // R17
			end
		end // R16
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			blinkCnt_q <= 32'h00000000;
			phase_q <= 1'b0;
		end else begin
			blinkCnt_q <= blinkCnt_d;
			phase_q <= phase_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Character generator addressing.

	logic [lmscp_pkg::DIGITS-1:0][6:0] char_q, char_d; // Font index per digit.
	logic [lmscp_pkg::DIGITS-1:0] inv_q, inv_d; // Invert pattern per digit.
	logic [lmscp_pkg::DIGITS-1:0] user_q, user_d; // Index falls in user RAM.
	logic [7:0] shown; // Byte in view for one digit.

	// Pick the plane in view, then split the byte into index and polarity.
	always_comb begin
		char_d = char_q;
		inv_d = inv_q;
		user_d = user_q;
		shown = 8'h00;
		for (int i = 0; i < lmscp_pkg::DIGITS; i++) begin
			shown = (blinkOn && phase_q) ? alternate_q[i] : primary_q[i]; // R16 R17
			char_d[i] = shown[6:0]; // R18
			inv_d[i] = shown[7]; // R19
			user_d[i] = (shown[6:0] >= lmscp_pkg::FONT_FIXED); // R20
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			char_q <= {lmscp_pkg::DIGITS{lmscp_pkg::DIGIT_RESET[6:0]}};
			inv_q <= '0;
			user_q <= '0;
		end else begin
			char_q <= char_d;
			inv_q <= inv_d;
			user_q <= user_d;
		end
	end

	assign digitChar = char_q;
	assign digitInvert = inv_q;
	assign digitUserFont = user_q;
	assign blinkPhase = phase_q;
	assign blinkEnabled = blinkOn;

endmodule

/* File: hw/lmscp_host.sv */
`timescale 1ns/1ns
// Serial master with an APB register front end.
module lmscp_host (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	lmscp_if.host link
);

	////////////////////////////////////////////////////////////////////////////
	// Return data synchroniser.

	logic [1:0] doutSync_q; // Stage 0 feeds only stage 1.

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			doutSync_q <= 2'h0;
		end else begin
			doutSync_q <= {doutSync_q[0], link.dout};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer.

	typedef enum logic [2:0] {
		LMSCP_IDLE = 3'h0,
		LMSCP_LEAD = 3'h1,
		LMSCP_HIGH = 3'h2,
		LMSCP_LOW = 3'h3,
		LMSCP_CSUP = 3'h4,
		LMSCP_TAIL = 3'h5,
		LMSCP_HOLD = 3'h6
	} lmscp_state_t;

	lmscp_state_t state_q, state_d; // Sequencer state.
	logic [3:0] cnt_q, cnt_d; // Cycles in the current half period.
	logic [3:0] bit_q, bit_d; // Bit being sent.
	logic [15:0] tx_q, tx_d; // Outgoing word, top bit on the wire.
	logic [15:0] rx_q, rx_d; // Bits seen on the return line.
	logic hold_q, hold_d; // Keep select low after this word.
	logic done_q, done_d; // Sticky word-complete flag.
	logic sclk_q, sclk_d;
	logic csB_q, csB_d;
	logic din_q, din_d;
	logic tick; // Half period over.
	logic busy; // A word is on the wire.
	logic apbWrite; // Access phase of a write.
	logic start; // Software asks for a word.

	assign tick = (cnt_q == lmscp_pkg::SCLK_HALF_LAST);
	assign busy = (state_q != LMSCP_IDLE) && (state_q != LMSCP_HOLD);
	assign apbWrite = psel && penable && pwrite;
	// Writes to the command register while busy are ignored.
	assign start = apbWrite && (paddr == lmscp_pkg::APB_CMD) && !busy;

	// Next state. Return data is sampled just as the clock rises, long
	// after the device moved it on the previous falling edge.
	always_comb begin
		state_d = state_q;
		cnt_d = tick ? 4'h0 : cnt_q + 4'h1;
		bit_d = bit_q;
		tx_d = tx_q;
		rx_d = rx_q;
		hold_d = hold_q;
		done_d = done_q;
		sclk_d = sclk_q;
		csB_d = csB_q;
		din_d = din_q;
		if (apbWrite && (paddr == lmscp_pkg::APB_STATUS) && pwdata[lmscp_pkg::STATUS_DONE_BIT]) begin
			done_d = 1'b0;
		end
		unique case (state_q)
			LMSCP_IDLE, LMSCP_HOLD: begin
				cnt_d = 4'h0;
				if (start) begin
					// Clock is already low; select falls, top bit first.
					tx_d = pwdata[15:0]; // R4
					hold_d = pwdata[lmscp_pkg::CMD_HOLD_BIT];
					din_d = pwdata[15]; // R9
					csB_d = 1'b0;
					bit_d = 4'h0;
					state_d = LMSCP_LEAD;
				end
			end
			LMSCP_LEAD, LMSCP_LOW: begin
				if (tick) begin
					rx_d = {rx_q[14:0], doutSync_q[1]}; // R14
					sclk_d = 1'b1;
					state_d = LMSCP_HIGH;
				end
			end
			LMSCP_HIGH: begin
				if (tick) begin
					if (bit_q != lmscp_pkg::BIT_LAST) begin
						sclk_d = 1'b0;
						tx_d = {tx_q[14:0], 1'b0};
						din_d = tx_q[14]; // R2 R9
						bit_d = bit_q + 4'h1;
						state_d = LMSCP_LOW;
					end else if (hold_q) begin
						// Chained word follows; select stays low.
						sclk_d = 1'b0;
						done_d = 1'b1;
						state_d = LMSCP_HOLD; // R6
					end else begin
						// Select rises while the clock is still high.
						csB_d = 1'b1; // R10
						state_d = LMSCP_CSUP;
					end
				end
			end
			LMSCP_CSUP: begin
				// The clock drops only after select is already high.
				if (tick) begin
					sclk_d = 1'b0; // R9 R10
					state_d = LMSCP_TAIL;
				end
			end
			LMSCP_TAIL: begin
				if (tick) begin
					done_d = 1'b1;
					state_d = LMSCP_IDLE;
				end
			end
			default: begin
				state_d = LMSCP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= LMSCP_IDLE;
			cnt_q <= 4'h0;
			bit_q <= 4'h0;
			tx_q <= 16'h0000;
			rx_q <= 16'h0000;
			hold_q <= 1'b0;
			done_q <= 1'b0;
			sclk_q <= 1'b0;
			csB_q <= 1'b1;
			din_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			hold_q <= hold_d;
			done_q <= done_d;
			sclk_q <= sclk_d;
			csB_q <= csB_d;
			din_q <= din_d;
		end
	end

	assign link.sclk = sclk_q;
	assign link.csB = csB_q;
	assign link.din = din_q;

	////////////////////////////////////////////////////////////////////////////
	// APB answer: no wait states.

	logic mapped; // Address names a register.

	assign mapped = (paddr == lmscp_pkg::APB_CMD) || (paddr == lmscp_pkg::APB_STATUS)
		|| (paddr == lmscp_pkg::APB_RXDATA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		prdata = 32'h00000000;
		if (paddr == lmscp_pkg::APB_CMD) begin
			prdata = {15'h0000, hold_q, tx_q};
		end else if (paddr == lmscp_pkg::APB_STATUS) begin
			prdata = {30'h00000000, done_q, busy};
		end else if (paddr == lmscp_pkg::APB_RXDATA) begin
			prdata = {16'h0000, rx_q};
		end
	end

endmodule

/* File: testbench/lmscp_checker.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Watches the serial link between host and device ends.
module lmscp_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic csB,
	input wire logic din,
	input wire logic dout
);
	logic sclkQ; // Serial clock one cycle ago.
	logic [3:0] riseCnt; // Rising serial edges in a frame, modulo sixteen.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////
	// Counts rises while selected, so chained words must come in whole sixteens.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclkQ <= 1'h0;
			riseCnt <= 4'h0;
		end else begin
			sclkQ <= sclk;
			if (csB) begin
				riseCnt <= 4'h0;
			end else if (sclk && !sclkQ) begin
				riseCnt <= riseCnt + 4'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////
	property p_csFall;
		$fell(csB) |-> !sclk [*8] ##1 sclk;
	endproperty
	a_csFall: assert property (p_csFall) else $error("serial clock not low after select");
	property p_sclkHigh;
		$rose(sclk) |-> sclk [*8];
	endproperty
	a_sclkHigh: assert property (p_sclkHigh) else $error("serial high phase too short");
	property p_sclkLow;
		$fell(sclk) && !csB |-> !sclk [*8];
	endproperty
	a_sclkLow: assert property (p_sclkLow) else $error("serial low phase too short");
	property p_csRise;
		$rose(csB) |-> sclk [*8] ##1 !sclk;
	endproperty
	a_csRise: assert property (p_csRise) else $error("select rose with clock low");
	property p_sclkStill;
		csB && !sclk |=> !sclk;
	endproperty
	a_sclkStill: assert property (p_sclkStill) else $error("serial clock moved outside a frame");
	property p_dinHold;
		!csB && sclk |-> $stable(din);
	endproperty
	a_dinHold: assert property (p_dinHold) else $error("data moved while clock high");
	property p_doutFall;
		$changed(dout) && !csB |-> !sclk;
	endproperty
	a_doutFall: assert property (p_doutFall) else $error("data out moved while clock high");
	property p_frame16;
		$rose(csB) |-> riseCnt == 4'h0;
	endproperty
	a_frame16: assert property (p_frame16) else $error("frame not a multiple of sixteen");
	// Main traffic seen on the link.
	c_frame: cover property ($rose(csB));
	c_dout: cover property ($changed(dout));
	c_chain: cover property ($fell(sclk) && !csB ##9 !sclk);
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Host and device face each other; a second device takes raw frames.
module testbench;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr; // APB address.
	logic [31:0] pwdata, prdata; // APB data.
	logic [3:0][6:0] dChar, dChar2; // Font index per digit.
	logic [3:0] dInv, dUser; // Inversion and user-font flags.
	logic bPh, bEn; // Blink phase and enable.
	int miscompares, cmpCount; // Tallies for the verdict.
	lmscp_if lnk();
	lmscp_if lnk2();
	lmscp_host i_lmscp_host(.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk.host));
	lmscp_dev #(.BLINK_HALF(16)) i_lmscp_dev(.clk(clk), .rst_b(rst_b), .link(lnk.dev), .digitChar(dChar),
		.digitInvert(dInv), .digitUserFont(dUser), .blinkPhase(bPh), .blinkEnabled(bEn));
	// The second device is driven by hand so frames can be cut short.
	lmscp_dev #(.BLINK_HALF(16)) i_lmscp_dev_2(.clk(clk), .rst_b(rst_b), .link(lnk2.dev), .digitChar(dChar2),
		.digitInvert(), .digitUserFont(), .blinkPhase(), .blinkEnabled());
	lmscp_checker i_lmscp_checker(.clk(clk), .rst_b(rst_b), .sclk(lnk.sclk), .csB(lnk.csB), .din(lnk.din),
		.dout(lnk.dout));
	////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Prints the tallies and the verdict, then stops.
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmpCount++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Sends one word (bit 16 keeps select low) and waits for done.
	task automatic send(input logic [16:0] w);
		logic [31:0] r;
		logic e;
		apb(1'h1, lmscp_pkg::APB_CMD, 32'(w), r, e);
		r = 32'h0;
		for (int n = 0; n < 300 && r[1] !== 1'h1; n++) begin
			apb(1'h0, lmscp_pkg::APB_STATUS, 32'h0, r, e);
		end
		chk("done", 32'h1, 32'(r[1]));
		apb(1'h1, lmscp_pkg::APB_STATUS, 32'h2, r, e);
		repeat (4) @(posedge clk);
	endtask
	// Word captured on data out during the last frame.
	task automatic rx(input logic [15:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'h0, lmscp_pkg::APB_RXDATA, 32'h0, r, e);
		chk("rxdata", 32'(exp), 32'(r[15:0]));
	endtask
	// Raw frame of eight bits on the second link, 130 ns a bit.
	task automatic bang(input logic [7:0] b);
		lnk2.csB <= 1'h0;
		for (int i = 7; i >= 0; i--) begin
			lnk2.din <= b[i];
			repeat (6) @(posedge clk);
			lnk2.sclk <= 1'h1;
			repeat (7) @(posedge clk);
			if (i > 0) begin
				lnk2.sclk <= 1'h0;
			end
		end
		lnk2.csB <= 1'h1;
		repeat (6) @(posedge clk);
		lnk2.sclk <= 1'h0;
		repeat (7) @(posedge clk);
	endtask
	task automatic waitPh(input logic p);
		for (int n = 0; n < 100 && bPh !== p; n++) begin
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////
	task automatic tReset;
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 4; i++) begin
			chk("char", 32'h20, 32'(dChar[i]));
		end
		chk("inv", 32'h0, 32'(dInv));
		chk("blink", 32'h0, 32'(bEn));
		apb(1'h0, lmscp_pkg::APB_STATUS, 32'h0, r, e);
		chk("status", 32'h0, r);
	endtask
	// Primary writes, with font index, inversion and user range.
	task automatic tPlanes;
		logic [7:0] d [4] = '{8'hC1, 8'h42, 8'hE9, 8'h67};
		logic [15:0] w, p;
		w = 16'h0;
		for (int i = 0; i < 4; i++) begin
			p = w;
			w = {1'h0, lmscp_pkg::ADDR_PRIMARY | 7'(i), d[i]};
			send({1'h0, w});
			chk("char", 32'(d[i][6:0]), 32'(dChar[i]));
			chk("inv", 32'(d[i][7]), 32'(dInv[i]));
			chk("user", 32'(d[i][6:0] >= 7'h68), 32'(dUser[i]));
			if (i > 0) begin
				rx(p);
			end
		end
	endtask
	// Reads come back in the second byte of the next frame.
	task automatic tRead;
		send(17'h0A0FF);
		send(17'h00000);
		rx(16'hA0C1);
		chk("char", 32'h41, 32'(dChar[0]));
		send(17'h04055);
		send(17'h06133);
		chk("char", 32'h33, 32'(dChar[1]));
		send(17'h0C0FF);
		send(17'h0E1FF);
		rx(16'hC055);
		send(17'h00000);
		rx(16'hE100);
	endtask
	// Two words under one select: only the last sixteen bits count.
	task automatic tChain;
		send(17'h12177);
		send(17'h00000);
		chk("char", 32'h33, 32'(dChar[1]));
		send(17'h10000);
		send(17'h02255);
		chk("char", 32'h55, 32'(dChar[2]));
	endtask
	task automatic tBlink;
		logic p;
		repeat (40) begin
			@(posedge clk);
			chk("phase", 32'h0, 32'(bPh));
		end
		chk("char", 32'h41, 32'(dChar[0]));
		send(17'h00408);
		chk("blink", 32'h1, 32'(bEn));
		send(17'h08400);
		for (int k = 0; k < 2; k++) begin
			p = (k == 0);
			waitPh(p);
			chk("char", p ? 32'h55 : 32'h41, 32'(dChar[0]));
			chk("inv", 32'(!p), 32'(dInv[0]));
			chk("char", 32'h33, 32'(dChar[1]));
		end
		send(17'h00400);
		rx(16'h8408);
		chk("blink", 32'h0, 32'(bEn));
		chk("phase", 32'h0, 32'(bPh));
	endtask
	task automatic tApbErr;
		logic [31:0] r;
		logic e;
		apb(1'h1, 12'h00C, 32'hFFFFFFFF, r, e);
		chk("slverr", 32'h1, 32'(e));
		apb(1'h0, 12'h00C, 32'h0, r, e);
		chk("unmapped", 32'h0, r);
	endtask
	// Short frames with clock noise between them while deselected.
	task automatic tRaw;
		bang(8'h20);
		for (int j = 0; j < 6; j++) begin
			lnk2.din <= 1'(j);
			lnk2.sclk <= 1'h1;
			repeat (6) @(posedge clk);
			lnk2.sclk <= 1'h0;
			repeat (7) @(posedge clk);
		end
		bang(8'h5A);
		repeat (5) @(posedge clk);
		chk("raw", 32'h5A, 32'(dChar2[0]));
	endtask
	////////////////////////////////////////////////////////////
	// Cuts a hang short; the whole run needs about 5600 cycles.
	initial begin
		#600000;
		miscompares++;
		final_report;
	end
	initial begin
		rst_b = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		lnk2.sclk = 1'h0;
		lnk2.csB = 1'h1;
		lnk2.din = 1'h0;
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		tReset;
		tPlanes;
		tRead;
		tChain;
		tBlink;
		tApbErr;
		tRaw;
		final_report;
	end
endmodule
